// *** design/mbce_engine.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Internal register access one cycle; others two cycles, address held, except the one-cycle reset dummy read and MBCE_AM_NONE addressing read
// - Cycle clock output is held high; its phase register never toggles
// - Opcode read in cycles 1-2, register B prefetched in cycle 3
// - Program counter increments once, at the end of opcode fetch cycle 2
// - Pending interrupt at fetch cycle 2 skips B prefetch, enters entry
// - Interrupt entry decrements program counter once, in cycle 4
// - Idle opcode 01 jumps to cycle 5, no program counter decrement
// - Entry cycle 5 writes status to stack pointer address
// - Vector read at FF00 plus offset; low cycle 10, high cycle 12
// - Vector offset chosen by asserted interrupt source
// - Push PC high cycle 13 at SP, low cycle 15 at SP+1; end 17
// - Reset starts with a dummy read cycle
// - Reset writes zero to 0100 in two-cycle write, cycles 3-4
// - Reset continues at entry cycle 7, then vector and stacking
// - Reset loads stack pointer with 01
// - Reset stores program counter into register pair A and B
// - Reset held five clocks; sequence starts after current cycle
// - Register-source forms: 4 or 6 addressing cycles
// - Immediate forms: 3 or 5 cycles; B-to-A form one cycle
// - Simple operations one cycle writing destination; compare no bus
// - Decimal add uses three cycles: write, read, write
// - Read/write high for reads; latch strobe all, enable external only
// - Two-cycle access: address first cycle, data on port C second
module mbce_engine
   import mbce_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        reset_req_n,
   input  wire logic        int_pending,
   input  wire logic [7:0]  int_vec_off,
   input  wire logic        periph_exp_mode,
   input  wire mbce_amode_e amode,
   input  wire mbce_fn_e    fn_kind,
   input  wire logic [7:0]  status_reg,
   input  wire logic [7:0]  port_c_in,
   output logic             machine_cycle_clock_output,
   output logic             read_write,
   output logic             address_latch_strobe,
   output logic             enable_strobe,
   output logic [7:0]       port_c_out,
   output logic             port_c_oe,
   output logic [7:0]       port_d_out,
   output logic [15:0]      program_counter,
   output logic [7:0]       stack_pointer,
   output logic [7:0]       opcode,
   output logic             seq_start
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   mbce_state_e st_ff, nxt_st;
   logic [4:0]  cyc_ff, nxt_cyc;
   logic [15:0] pc_ff, nxt_pc;
   logic [7:0]  sp_ff, nxt_sp;
   logic [7:0]  op_ff, nxt_op;
   logic [7:0]  vec_ff, nxt_vec;
   logic [15:0] ab_ff, nxt_ab;
   logic [15:0] newpc_ff, nxt_newpc;
   logic [2:0]  rcnt_ff, nxt_rcnt;
   logic        rhit_ff, nxt_rhit;
   logic        ph_ff, nxt_ph;
   logic        sh_ff, nxt_sh;
   mbce_cyc_s   cur;

   // Two-cycle external access helper
   function automatic mbce_cyc_s ext_rd(input logic [15:0] a);
      ext_rd = '{rd:1'b1, wr:1'b0, ext:1'b1, addr:a, wdata:8'h00};
   endfunction : ext_rd

   function automatic mbce_cyc_s reg_acc(input logic [15:0] a,
                                         input logic w,
                                         input logic [7:0] d);
      reg_acc = '{rd:!w, wr:w, ext:1'b0, addr:a, wdata:d};
   endfunction : reg_acc

   // Machine cycle is the clock period; phase is held at 0, so the output stays high
   assign machine_cycle_clock_output = ~ph_ff;

   // -------------------------------------------------------------------
   // Per-cycle bus decode
   // -------------------------------------------------------------------
   always_comb begin
      cur = '{rd:1'b0, wr:1'b0, ext:1'b0, addr:16'h0000, wdata:8'h00};
      case (st_ff)
         MBCE_FETCH: cur = ext_rd(pc_ff);
         MBCE_PREB:  cur = reg_acc(REG_B_ADDR, 1'b0, 8'h00);
         MBCE_RST: begin
            if (cyc_ff == 5'h1) cur = ext_rd(16'h0000);
            if (cyc_ff == 5'h3 || cyc_ff == 5'h4) begin
               cur = ext_rd(IRQ_OFF_ADDR);
               cur.rd = 1'b0;
               cur.wr = 1'b1;
            end
         end
         MBCE_INT: begin
            case (cyc_ff)
               5'h5: cur = reg_acc({8'h00, sp_ff}, 1'b1,
                                   status_reg);
               5'h9, 5'ha: cur = ext_rd(VEC_BASE + {8'h00, vec_ff});
               // Both vector pairs present the same address
               5'hb, 5'hc: cur = ext_rd(VEC_BASE + {8'h00, vec_ff});
               5'hd: cur = reg_acc({8'h00, sp_ff}, 1'b1,
                                   pc_ff[15:8]);
               5'hf: cur = reg_acc({8'h00, sp_ff + 8'h01}, 1'b1,
                                   pc_ff[7:0]);
               default: cur = cur;
            endcase
         end
         MBCE_ADDR: begin
            case (amode)
               MBCE_AM_B_A: cur = reg_acc(REG_A_ADDR, 1'b0, 8'h00);
               MBCE_AM_RN_A, MBCE_AM_RN_B, MBCE_AM_RN_RN: begin
                  if (cyc_ff <= 5'h2 || cyc_ff == 5'h4 || cyc_ff == 5'h5)
                     cur = ext_rd(cyc_ff <= 5'h2 ? pc_ff : pc_ff);
                  else if (cyc_ff == 5'h3)
                     cur = reg_acc(16'h0002, 1'b0, 8'h00);
                  else
                     cur = reg_acc(amode == MBCE_AM_RN_B ? REG_B_ADDR
                                                         : REG_A_ADDR,
                                   1'b0, 8'h00);
                  if (amode != MBCE_AM_RN_RN && cyc_ff == 5'h4)
                     cur = reg_acc(amode == MBCE_AM_RN_B ? REG_B_ADDR
                                                         : REG_A_ADDR,
                                   1'b0, 8'h00);
               end
               default: begin
                  if (cyc_ff <= 5'h2) cur = ext_rd(pc_ff);
                  else if (amode == MBCE_AM_IM_RN && cyc_ff <= 5'h4)
                     cur = ext_rd(pc_ff);
                  else
                     cur = reg_acc(amode == MBCE_AM_IM_B ? REG_B_ADDR
                                                         : REG_A_ADDR,
                                   1'b0, 8'h00);
               end
            endcase
         end
         MBCE_FUNC: begin
            if (fn_kind == MBCE_FN_ONE)
               cur = reg_acc(REG_A_ADDR, 1'b1, 8'h00);
            else if (fn_kind == MBCE_FN_DAC)
               cur = reg_acc(REG_A_ADDR, cyc_ff != 5'h2, 8'h00);
         end
         default: cur = cur;
      endcase
   end

   // Addressing length per mode
   function automatic logic [4:0] am_len(input mbce_amode_e m);
      case (m)
         MBCE_AM_RN_A, MBCE_AM_RN_B: am_len = 5'h4;
         MBCE_AM_RN_RN:              am_len = 5'h6;
         MBCE_AM_IM_A, MBCE_AM_IM_B: am_len = 5'h3;
         MBCE_AM_IM_RN:              am_len = 5'h5;
         MBCE_AM_B_A:                am_len = 5'h1;
         default:                    am_len = 5'h1;
      endcase
   endfunction : am_len

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;  nxt_cyc = cyc_ff + 5'h1;
      nxt_pc = pc_ff;  nxt_sp = sp_ff;  nxt_op = op_ff;
      nxt_vec = vec_ff;  nxt_ab = ab_ff;  nxt_newpc = newpc_ff;
      nxt_ph = ~ph_ff;
      nxt_rcnt = reset_req_n ? 3'h0
               : (rcnt_ff == RST_MIN_CLKS ? rcnt_ff : rcnt_ff + 3'h1);
      nxt_rhit = rhit_ff | (rcnt_ff == RST_MIN_CLKS);
      nxt_ph = 1'b0;
      nxt_sh = cur.ext & !sh_ff;
      // Reset taken only at end of the current machine cycle
      if (nxt_rhit && !(st_ff == MBCE_RST)) begin
         nxt_st = MBCE_RST;  nxt_cyc = 5'h1;  nxt_rhit = 1'b0;
      end else begin
         case (st_ff)
            MBCE_IDLE: begin nxt_st = MBCE_FETCH; nxt_cyc = 5'h1; end
            MBCE_FETCH: begin
               if (cyc_ff == 5'h2) begin
                  nxt_pc = pc_ff + 16'h0001;
                  nxt_op = port_c_in;
                  nxt_cyc = 5'h1;
                  nxt_st = MBCE_PREB;
                  if (int_pending) begin
                     nxt_st = MBCE_INT;
                     nxt_vec = int_vec_off;
                     nxt_cyc = (port_c_in == IDLE_OPCODE) ? 5'h5
                                                          : 5'h3;
                  end
               end
            end
            MBCE_PREB: begin nxt_st = MBCE_ADDR; nxt_cyc = 5'h1; end
            MBCE_INT: begin
               // One step back, undoing the single fetch increment
               if (cyc_ff == 5'h4)
                  nxt_pc = pc_ff - 16'h0001;
               if (cyc_ff == 5'ha) nxt_newpc[7:0] = port_c_in;
               if (cyc_ff == 5'hc) nxt_newpc[15:8] = port_c_in;
               if (cyc_ff == INT_LAST_CYC) begin
                  nxt_pc = newpc_ff;  nxt_sp = sp_ff + 8'h02;
                  nxt_st = MBCE_FETCH;  nxt_cyc = 5'h1;
               end
            end
            MBCE_RST: begin
               if (cyc_ff == 5'h1) begin
                  nxt_sp = SP_RST_VAL;
                  nxt_ab = pc_ff;
                  nxt_vec = 8'h00;
               end
               if (cyc_ff == 5'h4) begin
                  nxt_st = MBCE_INT;  nxt_cyc = 5'h7;
               end
            end
            MBCE_ADDR: begin
               // Step past each operand byte as its pair closes
               if (cyc_ff == 5'h2 ||
                   (cyc_ff == 5'h4 && amode == MBCE_AM_IM_RN) ||
                   (cyc_ff == 5'h5 && amode == MBCE_AM_RN_RN))
                  nxt_pc = pc_ff + 16'h0001;
               if (cyc_ff == am_len(amode)) begin
                  nxt_st = MBCE_FUNC;  nxt_cyc = 5'h1;
               end
            end
            MBCE_FUNC: begin
               if (fn_kind != MBCE_FN_DAC || cyc_ff == 5'h3) begin
                  nxt_st = MBCE_FETCH;  nxt_cyc = 5'h1;
               end
            end
            default: begin nxt_st = MBCE_IDLE; nxt_cyc = 5'h1; end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_ff <= MBCE_IDLE;  cyc_ff <= 5'h1;  pc_ff <= PC_RST_VAL;
         sp_ff <= SP_RST_VAL;  op_ff <= 8'h00;  vec_ff <= 8'h00;
         ab_ff <= 16'h0000;  newpc_ff <= 16'h0000;
         rcnt_ff <= 3'h0;  rhit_ff <= 1'b0;  ph_ff <= 1'b0;
         sh_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;  cyc_ff <= nxt_cyc;  pc_ff <= nxt_pc;
         sp_ff <= nxt_sp;  op_ff <= nxt_op;  vec_ff <= nxt_vec;
         ab_ff <= nxt_ab;  newpc_ff <= nxt_newpc;
         rcnt_ff <= nxt_rcnt;  rhit_ff <= nxt_rhit;  ph_ff <= nxt_ph;
         sh_ff <= nxt_sh;
      end
   end

   // -------------------------------------------------------------------
   // Pin drive; second half of a two-cycle pair puts data on port C
   // -------------------------------------------------------------------
   logic second_half;
   // Pair phase tracked, since pairs start on odd or even counts
   assign second_half = cur.ext && sh_ff;
   assign read_write           = !cur.wr;
   assign address_latch_strobe = cur.rd | cur.wr;
   assign enable_strobe        = cur.ext & (cur.rd | cur.wr);
   assign port_c_out = second_half ? cur.wdata : cur.addr[7:0];
   assign port_c_oe  = (cur.rd | cur.wr) & !(second_half & cur.rd);
   assign port_d_out = periph_exp_mode ? 8'h00 : cur.addr[15:8];
   assign program_counter = pc_ff;
   assign stack_pointer   = sp_ff;
   assign opcode          = op_ff;
   assign seq_start       = (st_ff == MBCE_FETCH) && (cyc_ff == 5'h1);

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   property p_pc_inc;
      @(posedge core_clk) disable iff (rst)
      (st_ff == MBCE_FETCH && cyc_ff == 5'h2 && !nxt_rhit)
         |=> (pc_ff == $past(pc_ff) + 16'h0001);
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc no inc");

   property p_int_skip;
      @(posedge core_clk) disable iff (rst || nxt_rhit)
      (st_ff == MBCE_FETCH && cyc_ff == 5'h2 && int_pending)
         |=> (st_ff == MBCE_INT);
   endproperty
   a_int_skip: assert property (p_int_skip) else $error("no int");

   property p_int_dec;
      @(posedge core_clk) disable iff (rst)
      (st_ff == MBCE_INT && cyc_ff == 5'h4 && !nxt_rhit)
         |=> (pc_ff == $past(pc_ff) - 16'h0001);
   endproperty
   a_int_dec: assert property (p_int_dec) else $error("pc dec");

   property p_stat_wr;
      @(posedge core_clk) disable iff (rst)
      (st_ff == MBCE_INT && cyc_ff == 5'h5)
         |-> (!read_write && port_c_out == sp_ff);
   endproperty
   a_stat_wr: assert property (p_stat_wr) else $error("st wr");

   property p_ena_ext;
      @(posedge core_clk) disable iff (rst)
      enable_strobe |-> address_latch_strobe;
   endproperty
   a_ena_ext: assert property (p_ena_ext) else $error("enable");

   property p_rst_sp;
      @(posedge core_clk) disable iff (rst)
      (st_ff == MBCE_RST && cyc_ff == 5'h1 && !nxt_rhit)
         |=> (sp_ff == SP_RST_VAL);
   endproperty
   a_rst_sp: assert property (p_rst_sp) else $error("sp rst");

   property p_rst_ab;
      @(posedge core_clk) disable iff (rst)
      (st_ff == MBCE_RST && cyc_ff == 5'h1 && !nxt_rhit)
         |=> (ab_ff == $past(pc_ff));
   endproperty
   a_rst_ab: assert property (p_rst_ab) else $error("ab rst");

   property p_rst_jump;
      @(posedge core_clk) disable iff (rst || nxt_rhit)
      (st_ff == MBCE_RST && cyc_ff == 5'h4)
         |=> (st_ff == MBCE_INT && cyc_ff == 5'h7);
   endproperty
   a_rst_jump: assert property (p_rst_jump) else $error("rst j");

   property p_nobus;
      @(posedge core_clk) disable iff (rst)
      (st_ff == MBCE_INT && cyc_ff == 5'he) |-> !address_latch_strobe;
   endproperty
   a_nobus: assert property (p_nobus) else $error("bus idle");

   c_int:  cover property (@(posedge core_clk) st_ff == MBCE_INT);
   c_rst:  cover property (@(posedge core_clk) st_ff == MBCE_RST);
   c_dac:  cover property (@(posedge core_clk)
                           st_ff == MBCE_FUNC && cyc_ff == 5'h3);

endmodule : mbce_engine

// *** design/mbce_pkg.sv ***
package mbce_pkg;

   // -------------------------------------------------------------------
   // Bus addresses and constants
   // -------------------------------------------------------------------
   localparam logic [15:0] VEC_BASE      = 16'hff00;
   localparam logic [15:0] IRQ_OFF_ADDR  = 16'h0100;
   localparam logic [7:0]  IDLE_OPCODE   = 8'h01;
   localparam logic [7:0]  SP_RST_VAL    = 8'h01;
   localparam logic [15:0] REG_A_ADDR    = 16'h0000;
   localparam logic [15:0] REG_B_ADDR    = 16'h0001;
   localparam logic [15:0] PC_RST_VAL    = 16'h0000;
   localparam logic [4:0]  INT_LAST_CYC  = 5'h11;
   localparam logic [2:0]  RST_MIN_CLKS  = 3'h5;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      MBCE_IDLE    = 4'h0,
      MBCE_FETCH   = 4'h1,
      MBCE_PREB    = 4'h2,
      MBCE_INT     = 4'h3,
      MBCE_RST     = 4'h4,
      MBCE_ADDR    = 4'h5,
      MBCE_FUNC    = 4'h6
   } mbce_state_e;

   typedef enum logic [2:0] {
      MBCE_AM_RN_A  = 3'h0,
      MBCE_AM_IM_A  = 3'h1,
      MBCE_AM_RN_B  = 3'h2,
      MBCE_AM_RN_RN = 3'h3,
      MBCE_AM_IM_B  = 3'h4,
      MBCE_AM_B_A   = 3'h5,
      MBCE_AM_IM_RN = 3'h6,
      MBCE_AM_NONE  = 3'h7
   } mbce_amode_e;

   typedef enum logic [1:0] {
      MBCE_FN_ONE  = 2'h0,
      MBCE_FN_CMP  = 2'h1,
      MBCE_FN_DAC  = 2'h2
   } mbce_fn_e;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        ext;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mbce_cyc_s;

endpackage : mbce_pkg

// *** dv/mbce_mem_model.sv ***
`timescale 1ns/1ps
module mbce_mem_model
   import mbce_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       enable_strobe,
   input  wire logic       port_c_oe,
   input  wire logic [7:0] port_c_out,
   input  wire logic [7:0] port_d_out,
   input  wire logic       idle_mode,
   output logic      [7:0] port_c_in
);
   // -------------------------------------------------------------------
   // Pair tracking: first enabled cycle carries address, second data
   // -------------------------------------------------------------------
   logic        phase_ff;
   logic [15:0] addr_ff;
   logic [7:0]  last_ff;
   logic [7:0]  rd_byte;

   assign rd_byte = idle_mode ? IDLE_OPCODE : (addr_ff[7:0] ^ 8'h5a);
   // Not driving: inverse of last value so stale data never passes
   assign port_c_in = (enable_strobe && !port_c_oe) ? rd_byte : ~last_ff;

   always_ff @(posedge core_clk) begin
      if (rst) last_ff <= 8'h00;
      else last_ff <= port_c_in;
      if (rst || !enable_strobe) begin
         phase_ff <= 1'b0;
      end else begin
         phase_ff <= ~phase_ff;
         if (!phase_ff) begin
            addr_ff <= {port_d_out, port_c_out};
         end
      end
   end
endmodule : mbce_mem_model

// *** dv/micro_sequenced_bus_cycle_engine_test.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
   $display("[ERR] %s exp %h got %h", nm, ex, gt); fail_count++; end end
module micro_sequenced_bus_cycle_engine_test;
   import mbce_pkg::*;
   logic core_clk, rst, reset_req_n, int_pending, periph_exp_mode;
   logic [7:0] int_vec_off, status_reg, port_c_in, port_c_out, port_d_out;
   logic [7:0] stack_pointer, opcode;
   logic [15:0] program_counter;
   logic mcco, read_write, address_latch_strobe, enable_strobe;
   logic port_c_oe, seq_start, idle_mode;
   mbce_amode_e amode;
   mbce_fn_e    fn_kind;
   int fail_count, tests_run, nxt_i;
   logic       r_rw[64], r_al[64], r_en[64], r_st[64];
   logic [7:0] r_c[64], r_d[64], r_sp[64];

   mbce_engine u_dut (.core_clk(core_clk), .rst(rst),
      .reset_req_n(reset_req_n), .int_pending(int_pending),
      .int_vec_off(int_vec_off), .periph_exp_mode(periph_exp_mode),
      .amode(amode), .fn_kind(fn_kind), .status_reg(status_reg),
      .port_c_in(port_c_in), .machine_cycle_clock_output(mcco),
      .read_write(read_write), .address_latch_strobe(address_latch_strobe),
      .enable_strobe(enable_strobe), .port_c_out(port_c_out),
      .port_c_oe(port_c_oe), .port_d_out(port_d_out),
      .program_counter(program_counter), .stack_pointer(stack_pointer),
      .opcode(opcode), .seq_start(seq_start));
   mbce_mem_model u_mem (.core_clk(core_clk), .rst(rst),
      .enable_strobe(enable_strobe), .port_c_oe(port_c_oe),
      .port_c_out(port_c_out), .port_d_out(port_d_out),
      .idle_mode(idle_mode), .port_c_in(port_c_in));

   // -------------------------------------------------------------------
   // Shared helpers
   // -------------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   task automatic wait_start;
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (seq_start !== 1'b1 && n < 80);
      if (n >= 80) `CHK("seq_start seen", 1'b1, 1'b0)
   endtask : wait_start
   // Samples settled outputs at each falling edge, starting now
   task automatic grab(input int n);
      for (int i = 0; i < n; i++) begin
         r_rw[i] = read_write; r_al[i] = address_latch_strobe;
         r_en[i] = enable_strobe; r_st[i] = seq_start;
         r_c[i] = port_c_out; r_d[i] = port_d_out; r_sp[i] = stack_pointer;
         if (i == 3) int_pending = 1'b0;
         if (i == 5) reset_req_n = 1'b1;
         @(negedge core_clk);
      end
   endtask : grab
   function automatic int am_len(input mbce_amode_e m);
      case (m)
         MBCE_AM_RN_A, MBCE_AM_RN_B: return 4;
         MBCE_AM_IM_A, MBCE_AM_IM_B: return 3;
         MBCE_AM_RN_RN:              return 6;
         MBCE_AM_IM_RN:              return 5;
         default:                    return 1;
      endcase
   endfunction : am_len
   function automatic int next_start;
      for (int i = 1; i < 64; i++) if (r_st[i] === 1'b1) return i;
      return 0;
   endfunction : next_start

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_fetch;
      wait_start;
      grab(4);
      `CHK("cycle clk", 1'b1, mcco)
      `CHK("f1 rw", 1'b1, r_rw[0] & r_al[0] & r_en[0])
      `CHK("f1 addr", PC_RST_VAL, {r_d[0], r_c[0]})
      `CHK("f2 addr", PC_RST_VAL, {r_d[1], r_c[1]})
      `CHK("opcode", PC_RST_VAL[7:0] ^ 8'h5a, opcode)
      `CHK("f3 int", 2'b10, {r_al[2], r_en[2]})
      `CHK("f3 addr", REG_B_ADDR[7:0], r_c[2])
      `CHK("am c1", PC_RST_VAL + 16'h0001, {r_d[3], r_c[3]})
   endtask : t_fetch
   task automatic t_modes(input mbce_fn_e f);
      int len;
      logic [2:0] dw;
      for (int m = 0; m < 7; m++) begin
         wait_start;
         amode = mbce_amode_e'(m);
         fn_kind = f;
         wait_start;
         grab(20);
         len = 3 + am_len(amode) + (f == MBCE_FN_DAC ? 3 : 1);
         `CHK("instr len", len, next_start())
         if (f == MBCE_FN_ONE) `CHK("fn wr", 1'b0, r_rw[len-1])
         if (f == MBCE_FN_CMP) `CHK("cmp bus", 1'b0, r_al[len-1])
         dw = {r_rw[len-3], r_rw[len-2], r_rw[len-1]};
         if (f == MBCE_FN_DAC) `CHK("dac order", 3'b010, dw)
      end
   endtask : t_modes
   task automatic t_int(input logic idl);
      int b;
      logic [7:0] sp0;
      wait_start;
      int_pending = 1'b1;
      int_vec_off = 8'h04;
      idle_mode = idl;
      sp0 = stack_pointer;
      grab(30);
      b = idl ? -3 : -1;
      `CHK("no prefetch", 1'b0, idl ? r_rw[2] : r_al[2])
      `CHK("st write", 1'b0, r_rw[b+5])
      `CHK("st addr", sp0, r_c[b+5])
      `CHK("vec lo", 16'hff04, {r_d[b+9], r_c[b+9]})
      `CHK("vec hi", 16'hff04, {r_d[b+11], r_c[b+11]})
      `CHK("pch wr", 1'b0, r_rw[b+13])
      `CHK("pcl wr", 1'b0, r_rw[b+15])
      `CHK("c17 idle", 1'b0, r_al[b+17])
      `CHK("entry end", b + 18, next_start())
      `CHK("sp step", sp0 + 8'h02, r_sp[b+18])
      `CHK("npc", idl ? 16'h0101 : 16'h5e5e, {r_d[b+18], r_c[b+18]})
      idle_mode = 1'b0;
   endtask : t_int
   task automatic t_reset;
      int j;
      wait_start;
      reset_req_n = 1'b0;
      grab(40);
      j = 0;
      for (int i = 2; i < 26; i++)
         if (j == 0 && r_rw[i] === 1'b0 && {r_d[i], r_c[i]} === IRQ_OFF_ADDR)
            j = i;
      `CHK("clr write", 1'b1, j > 0)
      `CHK("dummy rd", 1'b1, r_rw[j-2] & r_al[j-2])
      `CHK("clr data", 4'h4, {r_rw[j+1], r_en[j+1], r_c[j+1][1:0]})
      `CHK("rst vec", VEC_BASE, {r_d[j+4], r_c[j+4]})
      `CHK("rst sp", SP_RST_VAL, r_sp[j+8])
      `CHK("rst end", j + 13, next_start())
   endtask : t_reset
   task automatic t_pexp;
      periph_exp_mode = 1'b1;
      wait_start;
      `CHK("port d", 8'h00, port_d_out)
      periph_exp_mode = 1'b0;
   endtask : t_pexp

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      #(40 * 20000);
      fail_count++;
      final_report;
   end
   initial begin
      rst = 1'b1; reset_req_n = 1'b1; int_pending = 1'b0; idle_mode = 1'b0;
      int_vec_off = 8'h00; periph_exp_mode = 1'b0; status_reg = 8'ha5;
      amode = MBCE_AM_RN_A; fn_kind = MBCE_FN_ONE;
      fail_count = 0; tests_run = 0;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      t_fetch;
      t_modes(MBCE_FN_ONE);
      t_modes(MBCE_FN_CMP);
      t_modes(MBCE_FN_DAC);
      t_int(1'b0);
      t_int(1'b1);
      t_reset;
      t_pexp;
      final_report;
   end
endmodule : micro_sequenced_bus_cycle_engine_test
